// >>> vcs_cal_seq.v
// VCO calibration sequencer with zero delay feedback routing
`timescale 1ns/10ps
`default_nettype none
`include "vcs_regs.vh"
module vcs_cal_seq (
	// Clock, reset, clock enable
	input wire CLK,
	input wire RST_N,
	input wire CE,
	// Reference input clock, sampled level
	input wire REFERENCE_INPUT_CLOCK,
	// Written settings (take effect on commit)
	input wire CAL_START_BIT,
	input wire [1:0] CAL_DIV_SEL,
	input wire [13:0] R_RATIO,
	// Register commit strobe
	input wire IO_UPDATE,
	// Nonvolatile store power-up load
	input wire AUTOLOAD_DONE,
	input wire AUTOLOAD_CAL_EN,
	// Zero delay configuration
	input wire [1:0] ZD_MODE,
	input wire [1:0] FB_CHAN_SEL,
	input wire [2:0] R_DELAY_SEL,
	input wire [2:0] N_DELAY_SEL,
	// Feedback sources
	input wire [3:0] CHAN_DIV_OUT,
	input wire CLK_PIN_IN,
	input wire VCO_FB_IN,
	// Status and control outputs
	output reg CAL_DONE,
	output reg CAL_BUSY,
	output reg SYNC_HOLD,
	output reg LOOP_OPEN,
	output reg FB_TO_NDIV,
	output reg [1:0] FB_CHAN_ACT,
	output reg ZD_EXT_ACT,
	output reg REF_PATH_TICK,
	output reg FB_PATH_TICK
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	// Sequence states; idle waits for a pending request,
	// sync clears both dividers and the cycle count,
	// tune counts calibration clocks with the outputs held,
	// release closes the loop and close ends the busy window
	localparam ST_IDLE = 3'h0;
	localparam ST_SYNC = 3'h1;
	localparam ST_TUNE = 3'h2;
	localparam ST_RELEASE = 3'h3;
	localparam ST_CLOSE = 3'h4;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg start_act_reg;
	reg [1:0] cal_div_act_reg;
	reg [13:0] r_act_reg;
	reg ref_d_reg;
	reg fb_d_reg;
	reg req_reg;
	reg [`VCS_CAL_CNT_W-1:0] cal_cnt_reg;
	reg [`VCS_DLY_LEN-1:0] ref_line_reg;
	reg [`VCS_DLY_LEN-1:0] fb_line_reg;
	reg fb_mux;
	wire ref_edge;
	wire fb_edge;
	wire pfd_tick;
	wire cal_tick;
	wire div_clear;
	wire commit_rise;
	wire auto_req;

	// Calibration divider field to ratio
	function [13:0] cal_ratio;
		input [1:0] sel;
		begin
			if (sel == `VCS_CALDIV_2) begin
				cal_ratio = `VCS_RATIO_2;
			end else if (sel == `VCS_CALDIV_4) begin
				cal_ratio = `VCS_RATIO_4;
			end else if (sel == `VCS_CALDIV_8) begin
				cal_ratio = `VCS_RATIO_8;
			end else begin
				// Last code is the slowest ratio
				cal_ratio = `VCS_RATIO_16;
			end
		end
	endfunction

	// ----------------------------------------
	// Commit of written settings
	// ----------------------------------------
	// Start only on a committed 0 to 1 change of the start bit;
	// a commit of one over a committed one is ignored, so the
	// host must commit a zero between two calibrations
	assign commit_rise = IO_UPDATE & CAL_START_BIT & ~start_act_reg;
	// Automatic calibration after the power-up load
	assign auto_req = AUTOLOAD_DONE & AUTOLOAD_CAL_EN;

	// Active copies update only on the commit strobe
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			start_act_reg <= 1'b0;
			cal_div_act_reg <= `VCS_CALDIV_16;
			r_act_reg <= `VCS_R_RST;
			FB_CHAN_ACT <= `VCS_FB_CHAN_RST;
			ZD_EXT_ACT <= 1'b0;
		end else if (CE) begin
			if (IO_UPDATE) begin
				start_act_reg <= CAL_START_BIT;
				cal_div_act_reg <= CAL_DIV_SEL;
				// A zero ratio is replaced by one, the reset value of the R ratio
				r_act_reg <= (R_RATIO == 14'h0000) ? `VCS_R_RST : R_RATIO;
				FB_CHAN_ACT <= FB_CHAN_SEL;
				ZD_EXT_ACT <= (ZD_MODE == `VCS_ZD_EXTERNAL);
			end
		end
	end

	// Pending request, held until the sequencer is idle;
	// divider setting changes alone never raise it.
	// A start that arrives during a calibration waits here
	// and runs once after the busy window; further starts
	// in the same window merge into that one request
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			req_reg <= 1'b0;
		end else if (CE) begin
			if (commit_rise || auto_req) begin
				req_reg <= 1'b1;
			end else if (state_reg == ST_IDLE) begin
				req_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Calibration clock from the reference
	// ----------------------------------------
	// Rising edges of the sampled reference
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ref_d_reg <= 1'b0;
		end else if (CE) begin
			ref_d_reg <= REFERENCE_INPUT_CLOCK;
		end
	end
	// No reference edges means no progress; the reference must
	// stay below half the clock rate or edges are lost, and a
	// missing reference leaves the sequencer tuning indefinitely
	assign ref_edge = REFERENCE_INPUT_CLOCK & ~ref_d_reg;
	// Both dividers restart together so the first calibration
	// clock comes a full period after the sync step
	assign div_clear = (state_reg == ST_SYNC);

	// R counter gives the PFD rate
	vcs_div u_rdiv (
		.clk(CLK),
		.rst_n(RST_N),
		.ce(CE),
		.clear(div_clear),
		.tick_in(ref_edge),
		.ratio(r_act_reg),
		.tick_out(pfd_tick)
	);

	// Calibration divider from the PFD rate
	vcs_div u_caldiv (
		.clk(CLK),
		.rst_n(RST_N),
		.ce(CE),
		.clear(div_clear),
		.tick_in(pfd_tick),
		.ratio(cal_ratio(cal_div_act_reg)),
		.tick_out(cal_tick)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Next state
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (req_reg) begin
					state_next = ST_SYNC;
				end
			end
			ST_SYNC: begin
				state_next = ST_TUNE;
			end
			ST_TUNE: begin
				// The tick that completes the last cycle ends tuning
				if (cal_tick && cal_cnt_reg == `VCS_CAL_CYCLES - 13'h0001) begin
					state_next = ST_RELEASE;
				end
			end
			ST_RELEASE: begin
				state_next = ST_CLOSE;
			end
			ST_CLOSE: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// State, cycle count and status outputs
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= ST_IDLE;
			cal_cnt_reg <= {`VCS_CAL_CNT_W{1'b0}};
			CAL_DONE <= 1'b0;
			CAL_BUSY <= 1'b0;
			SYNC_HOLD <= 1'b0;
			LOOP_OPEN <= 1'b0;
		end else if (CE) begin
			state_reg <= state_next;
			case (state_reg)
				ST_IDLE: begin
					if (req_reg) begin
						CAL_DONE <= 1'b0;
						CAL_BUSY <= 1'b1;
						SYNC_HOLD <= 1'b1;
						LOOP_OPEN <= 1'b1;
					end
				end
				ST_SYNC: begin
					cal_cnt_reg <= {`VCS_CAL_CNT_W{1'b0}};
				end
				ST_TUNE: begin
					if (cal_tick) begin
						cal_cnt_reg <= cal_cnt_reg + 13'h0001;
					end
					if (state_next == ST_RELEASE) begin
						// Outputs resume before lock
						SYNC_HOLD <= 1'b0;
						CAL_DONE <= 1'b1;
					end
				end
				ST_RELEASE: begin
					LOOP_OPEN <= 1'b0;
				end
				ST_CLOSE: begin
					CAL_BUSY <= 1'b0;
				end
				default: begin
					CAL_BUSY <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Zero delay feedback routing
	// ----------------------------------------
	// Feedback multiplexers into the N divider; modes 00 and 10
	// keep the normal VCO feedback. The mode is used live, so a
	// change takes effect without a commit. Only the outer and
	// inner selects are modelled; the committed channel number is
	// reported for the channel logic outside this block.
	always @* begin
		if (ZD_MODE == `VCS_ZD_INTERNAL) begin
			fb_mux = CHAN_DIV_OUT[0];
		end else if (ZD_MODE == `VCS_ZD_EXTERNAL) begin
			fb_mux = CLK_PIN_IN;
		end else begin
			fb_mux = VCO_FB_IN;
		end
	end

	// Registered feedback and its edge
	// The edge detector rests low, matching the reset value
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			FB_TO_NDIV <= 1'b0;
			fb_d_reg <= 1'b0;
		end else if (CE) begin
			FB_TO_NDIV <= fb_mux;
			fb_d_reg <= FB_TO_NDIV;
		end
	end
	assign fb_edge = FB_TO_NDIV & ~fb_d_reg;

	// ----------------------------------------
	// R and N path delays
	// ----------------------------------------
	// Tapped delay lines on reference and feedback edges;
	// taps are whole clock cycles, so the finest step is one
	// clock and an edge closer than the line length to the next
	// one still appears as a separate tick
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ref_line_reg <= {`VCS_DLY_LEN{1'b0}};
			fb_line_reg <= {`VCS_DLY_LEN{1'b0}};
			REF_PATH_TICK <= 1'b0;
			FB_PATH_TICK <= 1'b0;
		end else if (CE) begin
			ref_line_reg <= {ref_line_reg[`VCS_DLY_LEN-2:0], ref_edge};
			fb_line_reg <= {fb_line_reg[`VCS_DLY_LEN-2:0], fb_edge};
			REF_PATH_TICK <= ref_line_reg[R_DELAY_SEL];
			FB_PATH_TICK <= fb_line_reg[N_DELAY_SEL];
		end
	end
endmodule
`default_nettype wire

// >>> vcs_cal_seq_assertions.sv
// Port checker for the calibration sequencer
`timescale 1ns/10ps
`default_nettype none
module vcs_chk (
	// Clock and inputs
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic IO_UPDATE,
	input wire logic CAL_START_BIT,
	input wire logic AUTOLOAD_DONE,
	input wire logic AUTOLOAD_CAL_EN,
	input wire logic [1:0] ZD_MODE,
	input wire logic [1:0] FB_CHAN_SEL,
	input wire logic [3:0] CHAN_DIV_OUT,
	input wire logic CLK_PIN_IN,
	// Outputs watched
	input wire logic CAL_DONE,
	input wire logic CAL_BUSY,
	input wire logic SYNC_HOLD,
	input wire logic LOOP_OPEN,
	input wire logic FB_TO_NDIV,
	input wire logic [1:0] FB_CHAN_ACT,
	input wire logic ZD_EXT_ACT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic com_reg;
	logic pend_reg;
	logic req;
	// Mirror of the committed start bit
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			com_reg <= 1'b0;
		else if (CE && IO_UPDATE)
			com_reg <= CAL_START_BIT;
	end
	// Request held until the sequencer is seen idle
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			pend_reg <= 1'b0;
		else if (req)
			pend_reg <= 1'b1;
		else if (CE && !CAL_BUSY)
			pend_reg <= 1'b0;
	end
	// Host or power-up start request
	assign req = CE && ((IO_UPDATE && CAL_START_BIT && !com_reg) ||
		(AUTOLOAD_DONE && AUTOLOAD_CAL_EN));
	sequence s_start; req && !CAL_BUSY; endsequence
	sequence s_end; $fell(SYNC_HOLD); endsequence
	a_start_answer: assert property (s_start |-> ##3 (SYNC_HOLD && !CAL_DONE))
		else $error("Start not answered");
	a_no_idle_start: assert property ($rose(CAL_BUSY) |-> $past(pend_reg))
		else $error("Start without request");
	a_sync_inside: assert property (SYNC_HOLD |-> CAL_BUSY && LOOP_OPEN && !CAL_DONE)
		else $error("Sync outside tuning");
	a_done_at_end: assert property (s_end |-> CAL_DONE)
		else $error("Done not set");
	a_loop_closes: assert property (s_end |=> $fell(LOOP_OPEN) ##1 $fell(CAL_BUSY))
		else $error("Loop close order");
	a_chan_commit: assert property (CE && IO_UPDATE |=> FB_CHAN_ACT == $past(FB_CHAN_SEL))
		else $error("Channel not committed");
	a_ext_commit: assert property (CE && IO_UPDATE |=> ZD_EXT_ACT == ($past(ZD_MODE) == 2'h3))
		else $error("Mode not committed");
	a_route_int: assert property (CE && ZD_MODE == 2'h1 |=> FB_TO_NDIV == $past(CHAN_DIV_OUT[0]))
		else $error("Internal route");
	a_route_ext: assert property (CE && ZD_MODE == 2'h3 |=> FB_TO_NDIV == $past(CLK_PIN_IN))
		else $error("External route");
endmodule
bind vcs_cal_seq vcs_chk u_chk (.CLK, .RST_N, .CE, .IO_UPDATE, .CAL_START_BIT, .AUTOLOAD_DONE,
	.AUTOLOAD_CAL_EN, .ZD_MODE, .FB_CHAN_SEL, .CHAN_DIV_OUT, .CLK_PIN_IN, .CAL_DONE, .CAL_BUSY,
	.SYNC_HOLD, .LOOP_OPEN, .FB_TO_NDIV, .FB_CHAN_ACT, .ZD_EXT_ACT);
`default_nettype wire

// >>> vcs_cal_seq_tb.sv
// Self-checking testbench for the calibration sequencer
`timescale 1ns/10ps
`default_nettype none
module vcs_cal_seq_tb;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, ref_clk = 1'b0, sbit = 1'b0, upd = 1'b0;
	logic al_done = 1'b0, al_en = 1'b0, pin = 1'b0, vfb = 1'b0;
	logic [1:0] div_sel = 2'h0, zd = 2'h0, fbsel = 2'h0;
	logic [13:0] r_ratio = 14'h0001;
	logic [3:0] cdo = 4'h0;
	logic [2:0] rsel = 3'h0, nsel = 3'h0;
	wire done, busy, sync_hold, loop_open, fb_nd, zd_ext, rtick, ftick;
	wire [1:0] fb_act;
	int fails = 0, checked = 0, cycles = 0, n, i, j;
	vcs_cal_seq dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .REFERENCE_INPUT_CLOCK(ref_clk),
		.CAL_START_BIT(sbit), .CAL_DIV_SEL(div_sel), .R_RATIO(r_ratio), .IO_UPDATE(upd),
		.AUTOLOAD_DONE(al_done), .AUTOLOAD_CAL_EN(al_en), .ZD_MODE(zd), .FB_CHAN_SEL(fbsel),
		.R_DELAY_SEL(rsel), .N_DELAY_SEL(nsel), .CHAN_DIV_OUT(cdo), .CLK_PIN_IN(pin),
		.VCO_FB_IN(vfb), .CAL_DONE(done), .CAL_BUSY(busy), .SYNC_HOLD(sync_hold),
		.LOOP_OPEN(loop_open), .FB_TO_NDIV(fb_nd), .FB_CHAN_ACT(fb_act), .ZD_EXT_ACT(zd_ext),
		.REF_PATH_TICK(rtick), .FB_PATH_TICK(ftick));
	// Clock and hang guard
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			fails = fails + 1;
			tally_and_finish;
		end
	end
	task tally_and_finish; begin
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end endtask
	task chk(input logic [15:0] s, e); begin
		checked = checked + 1;
		if (s !== e) begin
			fails = fails + 1;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	end endtask
	task wt(input int k); begin
		repeat (k) @(posedge clk);
		#1;
	end endtask
	task do_reset; begin
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
	end endtask
	task commit(input logic b); begin
		@(posedge clk);
		sbit <= b;
		upd <= 1'b1;
		@(posedge clk);
		upd <= 1'b0;
	end endtask
	// Full calibration, reference held off at first
	task t_first_cal; begin
		commit(1'b1);
		wt(2);
		chk({sync_hold, busy, loop_open, done}, 4'he);
		wt(30);
		chk({sync_hold, done}, 2'h2);
		n = 0;
		while (sync_hold === 1'b1 && n < 9000) begin
			@(posedge clk);
			ref_clk <= 1'b1;
			n = n + 1;
			repeat (3) @(posedge clk);
			ref_clk <= 1'b0;
			wt(3);
		end
		chk(n[15:0], 16'h2260);
		chk(done, 1'b1);
		wt(3);
		chk({loop_open, busy}, 2'h0);
	end endtask
	// Recommit rules, then abort by reset
	task t_recal; begin
		@(posedge clk);
		div_sel <= 2'h3;
		r_ratio <= 14'h0005;
		commit(1'b1);
		wt(4);
		chk(busy, 1'b0);
		commit(1'b0);
		commit(1'b1);
		wt(2);
		chk({sync_hold, done}, 2'h2);
		do_reset;
		wt(1);
		chk({busy, done, fb_act}, 4'h0);
	end endtask
	task al_pulse(input logic en); begin
		@(posedge clk);
		al_en <= en;
		al_done <= 1'b1;
		@(posedge clk);
		al_done <= 1'b0;
	end endtask
	// Power-up store load with and without calibration
	task t_autoload; begin
		al_pulse(1'b0);
		wt(4);
		chk(busy, 1'b0);
		al_pulse(1'b1);
		wt(2);
		chk(sync_hold, 1'b1);
		do_reset;
	end endtask
	// Feedback routing for every mode, and commit of channels 0, 1 and 2
	task t_zero_delay; begin
		for (i = 0; i < 4; i = i + 1) begin
			for (j = 0; j < 4; j = j + 1) begin
				@(posedge clk);
				zd <= i[1:0];
				cdo <= j[0] ? 4'h1 : 4'he;
				pin <= j[1];
				vfb <= j[0] ^ j[1];
				wt(2);
				chk(fb_nd, i == 1 ? j[0] : i == 3 ? j[1] : j[0] ^ j[1]);
			end
			@(posedge clk);
			fbsel <= (i == 1) ? 2'h0 : i[1:0] ^ 2'h2;
			commit(1'b0);
			wt(2);
			chk({zd_ext, fb_act}, {i == 3, fbsel});
		end
	end endtask
	// Path delay taps on reference and external feedback edges
	task t_path_delay; begin
		for (i = 0; i < 8; i = i + 1) begin
			@(posedge clk);
			zd <= 2'h3;
			pin <= 1'b0;
			ref_clk <= 1'b0;
			wt(12);
			@(posedge clk);
			rsel <= i[2:0];
			nsel <= i[2:0];
			ref_clk <= 1'b1;
			pin <= 1'b1;
			wt(i + 1);
			chk({rtick, ftick}, 2'h0);
			wt(1);
			chk({rtick, ftick}, 2'h2);
			wt(1);
			chk({rtick, ftick}, 2'h1);
		end
	end endtask
	initial begin
		do_reset;
		wt(1);
		chk({done, fb_act}, 3'h0);
		t_first_cal;
		t_recal;
		t_autoload;
		t_zero_delay;
		t_path_delay;
		tally_and_finish;
	end
endmodule
`default_nettype wire

// >>> vcs_div.v
// Enable-driven programmable divider producing one tick per N input ticks
`timescale 1ns/10ps
`default_nettype none
module vcs_div (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	input wire ce,
	// Control
	input wire clear,
	input wire tick_in,
	input wire [13:0] ratio,
	// Output tick
	output reg tick_out
);
	reg [13:0] cnt_reg;

	// Count input ticks, pulse when ratio reached
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 14'h0000;
			tick_out <= 1'b0;
		end else if (ce) begin
			tick_out <= 1'b0;
			if (clear) begin
				cnt_reg <= 14'h0000;
			end else if (tick_in) begin
				if (cnt_reg + 14'h0001 >= ratio) begin
					cnt_reg <= 14'h0000;
					tick_out <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 14'h0001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> vcs_regs.vh
// Constants for the VCO calibration sequencer and zero delay feedback select
//
// Summary of operation
// - Calibration runs only from divided reference clock
// - Power-up auto-load triggers automatic calibration
// - Auto calibration needs reference; else host restarts
// - First start bit commits on update strobe
// - Later starts need committed zero then one
// - Readable flag shows calibration finished
// - Sync held during tuning, then loop closes
// - Sync released without waiting for lock
// - Calibration clock is PFD divided by field
// - Calibration lasts exactly 4400 calibration clocks
// - Divider changes never start a calibration
// - Mode field 01 internal, 11 external feedback
// - Internal mode feeds channel divider 0 back
// - External mode feeds clock input pin back
// - Feedback channel field is committed and reported; routing uses divider 0
// - Programmable R and N path delays
`ifndef VCS_REGS_VH
`define VCS_REGS_VH

// Calibration length in calibration clock cycles
`define VCS_CAL_CYCLES 13'h1130
`define VCS_CAL_CNT_W 13
// Width of the R counter ratio
`define VCS_R_W 14
// Calibration divider field encodings
`define VCS_CALDIV_2 2'h0
`define VCS_CALDIV_4 2'h1
`define VCS_CALDIV_8 2'h2
`define VCS_CALDIV_16 2'h3
// Calibration divider ratios for each field code
`define VCS_RATIO_2 14'h0002
`define VCS_RATIO_4 14'h0004
`define VCS_RATIO_8 14'h0008
`define VCS_RATIO_16 14'h0010
// Reset value of the committed R ratio
`define VCS_R_RST 14'h0001
// Zero delay mode field encodings
`define VCS_ZD_INTERNAL 2'h1
`define VCS_ZD_EXTERNAL 2'h3
// Feedback channel default
`define VCS_FB_CHAN_RST 2'h0
// Path delay select width and line length
`define VCS_DLY_W 3
`define VCS_DLY_LEN 8

`endif
